/* File: src/mci_core.sv */
`timescale 1ns/1ps
// Contract
// - run bit starts scanning and limit checks; clearing it means standby.
// - clearing run bit does not release asserted interrupt pins.
// - interrupt pin drives only while the enable bit is one.
// - polarity one gives active-high open-source, zero active-low open-drain.
// - hold bit releases interrupt and reset/overtemp pins, flags unchanged.
// - hold bit halts scanning; clearing it resumes.
// - reset bit gives low pulse of at least 10 ms when reset selected.
// - reset bit clears itself once the pulse ends.
// - intrusion clear bit drives intrusion pin, self-clears once pin cleared.
// - general output pin follows control bit 6; zero drives low.
// - init bit restores power-on values of listed registers; reads zero.
// - control register resets to hold bit only.
// - voltage flags set when a voltage is outside its limits.
// - bit 7 of voltage flags reads zero after low on external input.
// - temperature flag supports one-time or default mode, per mask2 bit 6.
// - board temperature flag set on board temperature interrupt input.
// - tach flags set when fan count exceeds its limit.
// - intrusion flag set when intrusion input has gone high.
// - overtemperature flag one-time or default mode, per mask2 bit 7.
// - voltage mask bit one keeps matching flag off the interrupt pin.
// - both flag registers and voltage mask reset to zero; voltage flags read 8'h80.
// - reading a flag register returns then clears it.
// - after clear-on-read, interrupt deasserts until new flags arrive.
module mci_core
    import mci_pkg::*;
#(
    parameter int RST_CYCLES = RST_PULSE_CYC
) (
    // clock and reset
    input wire logic MCLK_I,
    input wire logic RST_N_I,
    // register port behind the address pointer
    input wire logic [7:0] REG_ADDR_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    input wire logic [7:0] REG_WDATA_I,
    output logic [7:0] REG_RDATA_O,
    // limit results from the scan loop
    input wire logic [6:0] VOLT_FAULT_I,
    input wire logic TEMP_FAULT_I,
    input wire logic TACH_A_FAULT_I,
    input wire logic TACH_B_FAULT_I,
    input wire logic OVERTEMP_FAULT_I,
    output logic SCAN_RUN_O,
    // neighbouring registers
    input wire logic [7:0] MASK2_I,
    input wire logic [7:0] SHARED_PIN_CTL_I,
    output logic INIT_PULSE_O,
    // pins sampled from outside
    input wire logic EXT_IRQ_N_I,
    input wire logic BOARD_TEMP_IRQ_INPUT_N_I,
    // intrusion pin
    input wire logic INTRUSION_INPUT_I,
    output logic INTRUSION_INPUT_O,
    output logic INTRUSION_INPUT_OE_O,
    // interrupt pin
    output logic IRQ_PIN_O,
    output logic IRQ_PIN_OE_O,
    // reset or overtemperature pin, open drain
    output logic RESET_OR_OVERTEMP_PIN_O,
    output logic RESET_OR_OVERTEMP_PIN_OE_O,
    // general output pin, open drain
    output logic GENERAL_OUTPUT_PIN_O,
    output logic GENERAL_OUTPUT_PIN_OE_O
);

    ////////////////////////////////////////////////////////////////////////
    // register state
    logic [7:0] monitor_control;
    logic [7:0] irq_flags_voltage;
    logic [7:0] irq_flags_thermal_fan;
    logic [7:0] irq_mask_voltage;
    // sticky low-seen on external input, shown inverted in bit 7
    logic ext_seen;

    logic wr_ctl;
    logic wr_mask;
    logic rd_volt;
    logic rd_thermal;
    logic init_req;

    always_comb begin
        wr_ctl = REG_WR_I && (REG_ADDR_I == ADDR_MONITOR_CONTROL);
        wr_mask = REG_WR_I && (REG_ADDR_I == ADDR_IRQ_MASK_VOLTAGE);
        rd_volt = REG_RD_I && (REG_ADDR_I == ADDR_IRQ_FLAGS_VOLTAGE);
        rd_thermal = REG_RD_I && (REG_ADDR_I == ADDR_IRQ_FLAGS_THERMAL_FAN);
        init_req = wr_ctl && REG_WDATA_I[CTL_INIT];
    end

    ////////////////////////////////////////////////////////////////////////
    // synchronised pins
    logic ext_irq_n;
    logic board_irq_n;
    logic intrusion;

    // active-low pins start released, else reset release looks like an event
    mci_sync #(
        .WIDTH(3),
        .RESET_VAL(3'h6)
    ) u_sync (
        .clk_i(MCLK_I),
        .rst_n_i(RST_N_I),
        .async_i({EXT_IRQ_N_I, BOARD_TEMP_IRQ_INPUT_N_I, INTRUSION_INPUT_I}),
        .sync_o({ext_irq_n, board_irq_n, intrusion})
    );

    ////////////////////////////////////////////////////////////////////////
    // scan control
    logic scan_run;

    always_comb begin
        // halted in standby and while the hold bit is set
        scan_run = monitor_control[CTL_RUN] && !monitor_control[CTL_HOLD];
    end

    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            SCAN_RUN_O <= 1'b0;
        end else begin
            SCAN_RUN_O <= scan_run;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reset pulse on the shared pin
    logic rst_fn_sel;
    logic os_fn_sel;
    logic rst_busy;
    logic rst_done;
    logic rst_start;

    always_comb begin
        rst_fn_sel = SHARED_PIN_CTL_I[SP_RST_SEL] && !SHARED_PIN_CTL_I[SP_OS_SEL];
        os_fn_sel = SHARED_PIN_CTL_I[SP_OS_SEL] && !SHARED_PIN_CTL_I[SP_RST_SEL];
        // the done cycle still sees the bit set; without the gate the pulse restarts
        rst_start = monitor_control[CTL_RST_PULSE] && rst_fn_sel && !rst_busy
            && !rst_done;
    end

    mci_pulse #(
        .CYCLES(RST_CYCLES)
    ) u_rst_pulse (
        .clk_i(MCLK_I),
        .rst_n_i(RST_N_I),
        .start_i(rst_start),
        .abort_i(init_req),
        .busy_o(rst_busy),
        .done_o(rst_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // monitor_control
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            monitor_control <= RST_MONITOR_CONTROL;
        end else if (init_req) begin
            // init bit itself never stores, so it reads back zero
            monitor_control <= RST_MONITOR_CONTROL;
        end else begin
            if (wr_ctl) begin
                monitor_control[CTL_GPO:CTL_RUN] <= REG_WDATA_I[CTL_GPO:CTL_RUN];
            end
            // pulse end clears the bit; a fresh write in the same cycle wins
            if (rst_done && !(wr_ctl && REG_WDATA_I[CTL_RST_PULSE])) begin
                monitor_control[CTL_RST_PULSE] <= 1'b0;
            end
            // without the reset function there is no pulse to wait for
            if (monitor_control[CTL_RST_PULSE] && !rst_fn_sel && !rst_busy && !wr_ctl) begin
                monitor_control[CTL_RST_PULSE] <= 1'b0;
            end
            // latch reads cleared while we pull it low
            if (monitor_control[CTL_CI_CLEAR] && !intrusion && INTRUSION_INPUT_OE_O
                && !(wr_ctl && REG_WDATA_I[CTL_CI_CLEAR])) begin
                monitor_control[CTL_CI_CLEAR] <= 1'b0;
            end
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            INIT_PULSE_O <= 1'b0;
        end else begin
            INIT_PULSE_O <= init_req;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // event detection for one-time mode
    logic temp_q;
    logic ot_q;
    logic temp_evt;
    logic ot_evt;

    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            temp_q <= 1'b0;
            ot_q <= 1'b0;
        end else if (scan_run) begin
            temp_q <= TEMP_FAULT_I;
            ot_q <= OVERTEMP_FAULT_I;
        end
    end

    always_comb begin
        // one-time flags only the entry into a fault, default flags every pass
        temp_evt = MASK2_I[M2_TEMP_ONCE] ? (TEMP_FAULT_I && !temp_q) : TEMP_FAULT_I;
        ot_evt = MASK2_I[M2_OT_ONCE] ? (OVERTEMP_FAULT_I && !ot_q) : OVERTEMP_FAULT_I;
    end

    ////////////////////////////////////////////////////////////////////////
    // flag sources and clear-on-read
    logic [7:0] set_volt;
    logic [7:0] set_thermal;

    always_comb begin
        set_volt = 8'h00;
        set_thermal = 8'h00;
        // scan results only count while the scan runs
        set_volt[VF_VOLT_LSB +: VF_VOLT_W] = scan_run ? VOLT_FAULT_I : 7'h00;
        set_thermal[TF_TEMP] = scan_run && temp_evt;
        set_thermal[TF_BOARD] = !board_irq_n;
        set_thermal[TF_TACH_A] = scan_run && TACH_A_FAULT_I;
        set_thermal[TF_TACH_B] = scan_run && TACH_B_FAULT_I;
        // ignored while we drive the latch clear
        set_thermal[TF_INTRUDE] = intrusion && !INTRUSION_INPUT_OE_O;
        set_thermal[TF_OVERTEMP] = scan_run && ot_evt;
    end

    // new events win over the read that clears
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I || init_req) begin
            irq_flags_voltage <= RST_IRQ_FLAGS_VOLTAGE;
        end else begin
            irq_flags_voltage <= (rd_volt ? 8'h00 : irq_flags_voltage) | set_volt;
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I || init_req) begin
            ext_seen <= 1'b0;
        end else begin
            ext_seen <= (rd_volt ? 1'b0 : ext_seen) | !ext_irq_n;
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I || init_req) begin
            irq_flags_thermal_fan <= RST_IRQ_FLAGS_THERMAL_FAN;
        end else begin
            irq_flags_thermal_fan <= (rd_thermal ? 8'h00 : irq_flags_thermal_fan)
                | set_thermal;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // irq_mask_voltage
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I || init_req) begin
            irq_mask_voltage <= RST_IRQ_MASK_VOLTAGE;
        end else if (wr_mask) begin
            irq_mask_voltage <= REG_WDATA_I;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data
    logic [7:0] volt_view;

    always_comb begin
        volt_view = irq_flags_voltage;
        volt_view[VF_EXT_IRQ] = !ext_seen;
    end

    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            REG_RDATA_O <= 8'h00;
        end else if (REG_RD_I) begin
            unique case (REG_ADDR_I)
                ADDR_MONITOR_CONTROL: REG_RDATA_O <= monitor_control;
                ADDR_IRQ_FLAGS_VOLTAGE: REG_RDATA_O <= volt_view;
                ADDR_IRQ_FLAGS_THERMAL_FAN: REG_RDATA_O <= irq_flags_thermal_fan;
                ADDR_IRQ_MASK_VOLTAGE: REG_RDATA_O <= irq_mask_voltage;
                default: REG_RDATA_O <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt pin
    logic [7:0] volt_live;
    logic irq_any;
    logic irq_active;

    always_comb begin
        volt_live = irq_flags_voltage;
        volt_live[VF_EXT_IRQ] = ext_seen;
        // second mask lives outside, thermal flags are gated by it
        irq_any = |(volt_live & ~irq_mask_voltage)
            || |(irq_flags_thermal_fan & ~MASK2_I & 8'h3F);
        // independent of the run bit, so standby keeps a raised pin
        irq_active = irq_any && monitor_control[CTL_IRQ_EN]
            && !monitor_control[CTL_HOLD];
    end

    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            IRQ_PIN_O <= 1'b0;
            IRQ_PIN_OE_O <= 1'b0;
        end else begin
            IRQ_PIN_O <= monitor_control[CTL_IRQ_POL];
            IRQ_PIN_OE_O <= irq_active;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reset or overtemperature pin
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            RESET_OR_OVERTEMP_PIN_O <= 1'b0;
            RESET_OR_OVERTEMP_PIN_OE_O <= 1'b0;
        end else begin
            RESET_OR_OVERTEMP_PIN_O <= 1'b0;
            RESET_OR_OVERTEMP_PIN_OE_O <= !monitor_control[CTL_HOLD]
                && ((rst_busy && rst_fn_sel)
                || (os_fn_sel && irq_flags_thermal_fan[TF_OVERTEMP]));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // intrusion latch clear and general output
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            INTRUSION_INPUT_O <= 1'b0;
            INTRUSION_INPUT_OE_O <= 1'b0;
            GENERAL_OUTPUT_PIN_O <= 1'b0;
            GENERAL_OUTPUT_PIN_OE_O <= 1'b0;
        end else begin
            INTRUSION_INPUT_O <= 1'b0;
            INTRUSION_INPUT_OE_O <= monitor_control[CTL_CI_CLEAR];
            GENERAL_OUTPUT_PIN_O <= 1'b0;
            // open drain: one releases the pin to the pull-up
            GENERAL_OUTPUT_PIN_OE_O <= !monitor_control[CTL_GPO];
        end
    end

endmodule

/* File: src/mci_pkg.sv */
package mci_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register offsets on the address pointer
    localparam logic [7:0] ADDR_MONITOR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_IRQ_FLAGS_VOLTAGE = 8'h01;
    localparam logic [7:0] ADDR_IRQ_FLAGS_THERMAL_FAN = 8'h02;
    localparam logic [7:0] ADDR_IRQ_MASK_VOLTAGE = 8'h03;

    ////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0] RST_MONITOR_CONTROL = 8'h08;
    localparam logic [7:0] RST_IRQ_FLAGS_VOLTAGE = 8'h00;
    localparam logic [7:0] RST_IRQ_FLAGS_THERMAL_FAN = 8'h00;
    localparam logic [7:0] RST_IRQ_MASK_VOLTAGE = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // monitor_control fields
    localparam int CTL_RUN = 0;
    localparam int CTL_IRQ_EN = 1;
    localparam int CTL_IRQ_POL = 2;
    localparam int CTL_HOLD = 3;
    localparam int CTL_RST_PULSE = 4;
    localparam int CTL_CI_CLEAR = 5;
    localparam int CTL_GPO = 6;
    localparam int CTL_INIT = 7;

    ////////////////////////////////////////////////////////////////////////
    // irq_flags_voltage fields
    localparam int VF_VOLT_LSB = 0;
    localparam int VF_VOLT_W = 7;
    localparam int VF_EXT_IRQ = 7;

    // irq_flags_thermal_fan fields
    localparam int TF_TEMP = 0;
    localparam int TF_BOARD = 1;
    localparam int TF_TACH_A = 2;
    localparam int TF_TACH_B = 3;
    localparam int TF_INTRUDE = 4;
    localparam int TF_OVERTEMP = 5;

    // second mask register fields that pick one-time mode
    localparam int M2_TEMP_ONCE = 6;
    localparam int M2_OT_ONCE = 7;

    // shared-pin control fields
    localparam int SP_OS_SEL = 6;
    localparam int SP_RST_SEL = 7;

    ////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_KHZ = 20000;
    localparam int RST_PULSE_MS = 10;
    localparam int RST_PULSE_CYC = RST_PULSE_MS * CLK_KHZ;

endpackage

/* File: src/mci_sync.sv */
`timescale 1ns/1ps
module mci_sync #(
    parameter int WIDTH = 1,
    // idle level of each pin, so reset release shows no false event
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // data
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] stage1;

    // first stage is read only by the second
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            stage1 <= RESET_VAL;
            sync_o <= RESET_VAL;
        end else begin
            stage1 <= async_i;
            sync_o <= stage1;
        end
    end

endmodule

/* File: src/mci_pulse.sv */
`timescale 1ns/1ps
module mci_pulse #(
    parameter int CYCLES = 200000
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // control
    input wire logic start_i,
    input wire logic abort_i,
    output logic busy_o,
    output logic done_o
);

    localparam int CW = $clog2(CYCLES + 1);

    logic [CW-1:0] count;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i || abort_i) begin
            count <= '0;
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end else if (busy_o) begin
            done_o <= (count == CW'(CYCLES - 1));
            busy_o <= (count != CW'(CYCLES - 1));
            count <= count + CW'(1);
        end else begin
            done_o <= 1'b0;
            count <= '0;
            busy_o <= start_i;
        end
    end

endmodule

/* File: sim/mci_core_asserts.sv */
`timescale 1ns/1ps
module mci_core_asserts #(
    parameter int RST_CYCLES = 20
) (
    // clock and reset
    input wire logic MCLK_I,
    input wire logic RST_N_I,
    // register port
    input wire logic [7:0] REG_ADDR_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    input wire logic [7:0] REG_WDATA_I,
    input wire logic [7:0] REG_RDATA_O,
    // status and neighbours
    input wire logic SCAN_RUN_O,
    input wire logic INIT_PULSE_O,
    input wire logic [7:0] SHARED_PIN_CTL_I,
    // pins
    input wire logic INTRUSION_INPUT_O,
    input wire logic INTRUSION_INPUT_OE_O,
    input wire logic IRQ_PIN_O,
    input wire logic IRQ_PIN_OE_O,
    input wire logic RESET_OR_OVERTEMP_PIN_O,
    input wire logic RESET_OR_OVERTEMP_PIN_OE_O,
    input wire logic GENERAL_OUTPUT_PIN_O,
    input wire logic GENERAL_OUTPUT_PIN_OE_O
);
    ////////////////////////////////////////////////////////////////
    logic [31:0] low_cnt;
    logic [7:0] mask_sh;
    wire ctl_wr = REG_WR_I && REG_ADDR_I == 8'h00 && !REG_WDATA_I[7];
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!RST_N_I);

    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I || !RESET_OR_OVERTEMP_PIN_OE_O) begin
            low_cnt <= '0;
        end else begin
            low_cnt <= low_cnt + 1;
        end
    end

    // shadow clears on the init write itself, in step with the register
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I || (REG_WR_I && REG_ADDR_I == 8'h00 && REG_WDATA_I[7])) begin
            mask_sh <= 8'h00;
        end else if (REG_WR_I && REG_ADDR_I == 8'h03) begin
            mask_sh <= REG_WDATA_I;
        end
    end

    ////////////////////////////////////////////////////////////////
    gpo_drive_low_a: assert property (GENERAL_OUTPUT_PIN_OE_O
        |-> !GENERAL_OUTPUT_PIN_O) else $error("gpo drives high");
    gpo_follow_a: assert property (ctl_wr ##1 !REG_WR_I
        |=> GENERAL_OUTPUT_PIN_OE_O == !$past(REG_WDATA_I[6], 2)) else $error("gpo mismatch");
    irq_enable_a: assert property (ctl_wr && !REG_WDATA_I[1] ##1 !REG_WR_I
        |=> !IRQ_PIN_OE_O) else $error("irq drives while disabled");
    irq_polarity_a: assert property (ctl_wr ##1 !REG_WR_I ##1 IRQ_PIN_OE_O
        |-> IRQ_PIN_O == $past(REG_WDATA_I[2], 2)) else $error("irq polarity wrong");
    hold_pins_a: assert property (ctl_wr && REG_WDATA_I[3] ##1 !REG_WR_I
        |=> !IRQ_PIN_OE_O && !RESET_OR_OVERTEMP_PIN_OE_O) else $error("hold not releasing");
    scan_run_a: assert property (ctl_wr ##1 !REG_WR_I
        |=> SCAN_RUN_O == ($past(REG_WDATA_I[0], 2) && !$past(REG_WDATA_I[3], 2)))
        else $error("scan run wrong");
    rst_open_drain_a: assert property (RESET_OR_OVERTEMP_PIN_OE_O
        |-> !RESET_OR_OVERTEMP_PIN_O) else $error("reset pin drives high");
    rst_width_a: assert property ($fell(RESET_OR_OVERTEMP_PIN_OE_O)
        && SHARED_PIN_CTL_I[7:6] == 2'b10 |-> low_cnt >= RST_CYCLES) else $error("reset short");
    ci_open_drain_a: assert property (INTRUSION_INPUT_OE_O |-> !INTRUSION_INPUT_O)
        else $error("intrusion pin drives high");
    mask_read_a: assert property (REG_RD_I && REG_ADDR_I == 8'h03
        |=> REG_RDATA_O == $past(mask_sh)) else $error("mask readback wrong");
endmodule

bind mci_core mci_core_asserts #(.RST_CYCLES(RST_CYCLES)) u_chk (.MCLK_I, .RST_N_I,
    .REG_ADDR_I, .REG_WR_I, .REG_RD_I, .REG_WDATA_I, .REG_RDATA_O, .SCAN_RUN_O, .INIT_PULSE_O,
    .SHARED_PIN_CTL_I, .INTRUSION_INPUT_O, .INTRUSION_INPUT_OE_O, .IRQ_PIN_O, .IRQ_PIN_OE_O,
    .RESET_OR_OVERTEMP_PIN_O, .RESET_OR_OVERTEMP_PIN_OE_O, .GENERAL_OUTPUT_PIN_O,
    .GENERAL_OUTPUT_PIN_OE_O);

/* File: sim/mci_host.sv */
`timescale 1ns/1ps
module mci_host (
    // clock
    input wire logic clk_i,
    // register port
    input wire logic [7:0] rdata_i,
    output logic [7:0] addr_o,
    output logic wr_o,
    output logic rd_o,
    output logic [7:0] wdata_o
);
    initial begin
        addr_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
        wdata_o = 8'h00;
    end

    // idle bus shows inverted values so stale data never looks valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(negedge clk_i);
        wr_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_i);
        addr_o = a;
        rd_o = 1'b1;
        @(negedge clk_i);
        rd_o = 1'b0;
        addr_o = ~a;
        d = rdata_i;
    endtask
endmodule

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
module tb_top
    import mci_pkg::*;
;
    localparam int RC = 20;
    localparam logic [7:0] A_CTL = ADDR_MONITOR_CONTROL;
    localparam logic [7:0] A_F1 = ADDR_IRQ_FLAGS_VOLTAGE;
    localparam logic [7:0] A_F2 = ADDR_IRQ_FLAGS_THERMAL_FAN;
    localparam logic [7:0] A_M1 = ADDR_IRQ_MASK_VOLTAGE;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr, wdata, rdata;
    logic [7:0] mask2 = 8'h00;
    logic [7:0] shared = 8'h00;
    logic wr, rd, scan_run, init_p, ci_o, ci_oe, irq_o, irq_oe, ro_o, ro_oe, gpo_o, gpo_oe;
    logic [6:0] volt = 7'h00;
    logic temp = 1'b0, tch_a = 1'b0, tch_b = 1'b0, ot = 1'b0;
    logic ext_n = 1'b1, board_n = 1'b1, latch = 1'b0;
    wire logic ci_w;
    int fails = 0, check_count = 0;

    always #25 clk = ~clk;
    // intrusion pin as the external latch shows it; the scenario clears the latch
    assign ci_w = ci_oe ? ci_o : latch;

    mci_host h (.clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wr_o(wr), .rd_o(rd),
        .wdata_o(wdata));
    mci_core #(.RST_CYCLES(RC)) dut (.MCLK_I(clk), .RST_N_I(rst_n), .REG_ADDR_I(addr),
        .REG_WR_I(wr), .REG_RD_I(rd), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata),
        .VOLT_FAULT_I(volt), .TEMP_FAULT_I(temp), .TACH_A_FAULT_I(tch_a),
        .TACH_B_FAULT_I(tch_b), .OVERTEMP_FAULT_I(ot), .SCAN_RUN_O(scan_run),
        .MASK2_I(mask2), .SHARED_PIN_CTL_I(shared), .INIT_PULSE_O(init_p),
        .EXT_IRQ_N_I(ext_n), .BOARD_TEMP_IRQ_INPUT_N_I(board_n), .INTRUSION_INPUT_I(ci_w),
        .INTRUSION_INPUT_O(ci_o), .INTRUSION_INPUT_OE_O(ci_oe), .IRQ_PIN_O(irq_o),
        .IRQ_PIN_OE_O(irq_oe), .RESET_OR_OVERTEMP_PIN_O(ro_o),
        .RESET_OR_OVERTEMP_PIN_OE_O(ro_oe), .GENERAL_OUTPUT_PIN_O(gpo_o),
        .GENERAL_OUTPUT_PIN_OE_O(gpo_oe));

    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        check_count++;
        if (s !== e) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic chk1(input logic s, input logic e);
        chk({7'h00, s}, {7'h00, e});
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] v;
        h.rd(a, v);
        chk(v, e);
    endtask

    task automatic vpulse(input logic [6:0] b);
        @(negedge clk);
        volt = b;
        repeat (3) @(negedge clk);
        volt = 7'h00;
        repeat (3) @(negedge clk);
    endtask

    task automatic end_of_test();
        if (fails == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rdc(A_CTL, RST_MONITOR_CONTROL);
        rdc(A_F1, 8'h80);
        rdc(A_F2, 8'h00);
        rdc(A_M1, 8'h00);
        chk1(gpo_oe, 1'b1);
        chk1(scan_run, 1'b0);
    endtask

    task automatic t_irq();
        h.wr(A_M1, 8'h00);
        h.wr(A_CTL, 8'h03);
        vpulse(7'h08);
        chk1(irq_oe, 1'b1);
        chk1(irq_o, 1'b0);
        h.wr(A_CTL, 8'h02);
        repeat (3) @(negedge clk);
        chk1(irq_oe, 1'b1);
        rdc(A_F1, 8'h88);
        repeat (3) @(negedge clk);
        chk1(irq_oe, 1'b0);
        rdc(A_F1, 8'h80);
    endtask

    task automatic t_pol();
        h.wr(A_CTL, 8'h07);
        vpulse(7'h01);
        chk1(irq_o, 1'b1);
        h.wr(A_M1, 8'h01);
        repeat (3) @(negedge clk);
        chk1(irq_oe, 1'b0);
        rdc(A_M1, 8'h01);
        h.wr(A_M1, 8'h00);
        repeat (3) @(negedge clk);
        chk1(irq_oe, 1'b1);
        h.wr(A_CTL, 8'h05);
        repeat (3) @(negedge clk);
        chk1(irq_oe, 1'b0);
        rdc(A_F1, 8'h81);
    endtask

    task automatic t_hold();
        h.wr(A_CTL, 8'h03);
        vpulse(7'h02);
        h.wr(A_CTL, 8'h0B);
        repeat (3) @(negedge clk);
        chk1(irq_oe, 1'b0);
        chk1(scan_run, 1'b0);
        vpulse(7'h04);
        rdc(A_F1, 8'h82);
        h.wr(A_CTL, 8'h01);
        repeat (3) @(negedge clk);
        chk1(scan_run, 1'b1);
        h.wr(A_CTL, 8'h00);
        vpulse(7'h10);
        rdc(A_F1, 8'h80);
    endtask

    task automatic t_pins();
        h.wr(A_CTL, 8'h01);
        @(negedge clk);
        {ext_n, board_n, latch, temp, tch_a, tch_b, ot} = 7'b0011111;
        repeat (4) @(negedge clk);
        {ext_n, board_n, latch, temp, tch_a, tch_b, ot} = 7'b1100000;
        repeat (4) @(negedge clk);
        rdc(A_F1, 8'h00);
        rdc(A_F2, 8'h3F);
        // temperature one-time, overtemperature default
        mask2 = 8'h40;
        {temp, ot} = 2'b11;
        repeat (4) @(negedge clk);
        rdc(A_F2, 8'h21);
        shared = 8'h40;
        repeat (4) @(negedge clk);
        chk1(ro_oe, 1'b1);
        rdc(A_F2, 8'h20);
        {temp, ot} = 2'b00;
        rdc(A_F2, 8'h20);
        repeat (3) @(negedge clk);
        chk1(ro_oe, 1'b0);
        mask2 = 8'h00;
        shared = 8'h00;
    endtask

    task automatic t_ci();
        latch = 1'b1;
        repeat (4) @(negedge clk);
        rdc(A_F2, 8'h10);
        h.wr(A_CTL, 8'h21);
        @(negedge clk);
        chk1(ci_oe, 1'b1);
        chk1(ci_w, 1'b0);
        latch = 1'b0;
        repeat (8) @(negedge clk);
        chk1(ci_oe, 1'b0);
        rdc(A_CTL, 8'h01);
    endtask

    task automatic t_rst();
        int n;
        n = 0;
        shared = 8'h80;
        h.wr(A_CTL, 8'h10);
        while (ro_oe !== 1'b1 && n < 6) begin
            @(negedge clk);
            n++;
        end
        repeat (RC - 1) @(negedge clk);
        chk1(ro_oe, 1'b1);
        chk1(ro_o, 1'b0);
        repeat (6) @(negedge clk);
        chk1(ro_oe, 1'b0);
        rdc(A_CTL, 8'h00);
        shared = 8'h00;
        h.wr(A_CTL, 8'h10);
        repeat (3) @(negedge clk);
        chk1(ro_oe, 1'b0);
        rdc(A_CTL, 8'h00);
    endtask

    task automatic t_init();
        logic seen;
        seen = 1'b0;
        h.wr(A_M1, 8'h5A);
        h.wr(A_F1, 8'hFF);
        h.wr(A_CTL, 8'h47);
        repeat (3) @(negedge clk);
        chk1(gpo_oe, 1'b0);
        h.wr(A_CTL, 8'h80);
        repeat (3) begin
            seen = seen | (init_p === 1'b1);
            @(negedge clk);
        end
        chk1(seen, 1'b1);
        rdc(A_CTL, 8'h08);
        rdc(A_M1, 8'h00);
        rdc(A_F1, 8'h80);
        rdc(8'h09, 8'h00);
        chk1(gpo_oe, 1'b1);
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        t_reset();
        t_irq();
        t_pol();
        t_hold();
        t_pins();
        t_ci();
        t_rst();
        t_init();
        end_of_test();
    end

    // the sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        end_of_test();
    end
endmodule
